//--- ahp_pkg.sv
// package of the adc serial host port: input word layout, word lengths,
// reset values and timing counts shared by both ends of the link.
// assumes a 125 MHz core clock on the host end and a 2 MHz conversion clock.
package ahp_pkg;

    localparam int RES_W          = 10;
    localparam int IN_W           = 8;
    localparam int CNT_W          = 5;

    // input word bit positions, first bit received lands in bit 7
    localparam int POS_ADDR_HI    = 7;
    localparam int POS_ADDR_LO    = 4;
    localparam int POS_POLARITY   = 3;
    localparam int POS_ORDER      = 2;
    localparam int POS_WL_HI      = 1;
    localparam int POS_WL_LO      = 0;

    // word length codes
    localparam logic [1:0] WL_8   = 2'h0;
    localparam logic [1:0] WL_10  = 2'h1;
    localparam logic [1:0] WL_12  = 2'h2;
    localparam logic [1:0] WL_16  = 2'h3;

    // reset values: msb first, unipolar
    localparam logic ORDER_RST    = 1'h1;
    localparam logic POLARITY_RST = 1'h1;

    // timing
    localparam int CORE_PERIOD_NS = 8;
    localparam int ACLK_PERIOD_NS = 500;
    localparam int CONV_ACLK      = 44;
    localparam int CYCLE_ACLK     = 48;
    localparam int SU_EXTRA_NS    = 1000;
    localparam int SETUP_NS       = 2 * ACLK_PERIOD_NS + SU_EXTRA_NS;
    localparam int SETUP_CYC      = (SETUP_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int CONV_WAIT_NS   = CYCLE_ACLK * ACLK_PERIOD_NS;
    localparam int CONV_WAIT_CYC  = (CONV_WAIT_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
    localparam int SCLK_HALF_CYC  = 4;

    function automatic logic [CNT_W-1:0] wl_bits(input logic [1:0] code);
        logic [CNT_W-1:0] n;
        n = 5'h10;
        case (code)
            WL_8:    n = 5'h08;
            WL_10:   n = 5'h0a;
            WL_12:   n = 5'h0c;
            default: n = 5'h10;
        endcase
        return n;
    endfunction

endpackage

//--- ahp_link_if.sv
// four wire link between the converter end and the host end.
// the converter end forces data-out low whenever sdo_oe is low.
`timescale 1ns/100ps
interface ahp_link_if;
    logic sclk;
    logic cs_n;
    logic sdi;
    logic sdo;
    logic sdo_oe;

    modport dev (
        input  sclk,
        input  cs_n,
        input  sdi,
        output sdo,
        output sdo_oe
    );

    modport host (
        output sclk,
        output cs_n,
        output sdi,
        input  sdo
    );
endinterface

//--- ahp_device.sv
// converter end of the adc serial host port: chip select deglitch,
// full duplex shifter on the shift clock, conversion sequencing.
// assumes sclk stays low outside frames and the host waits out conversions.
`timescale 1ns/100ps
module ahp_device
    import ahp_pkg::*;
#(
    parameter int CONV_CYC = ahp_pkg::CONV_ACLK
) (
    ahp_link_if.dev                    link,
    input  wire logic                  conv_clk,
    input  wire logic                  rst_n,
    input  wire logic [ahp_pkg::RES_W-1:0] sample_value,
    output logic      [3:0]            mux_address,
    output logic                       conv_busy,
    output logic                       cs_seen
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    typedef enum logic {
        AHP_CV_IDLE,
        AHP_CV_RUN
    } ahp_cv_e;

    logic                 cs_m1;
    logic                 cs_m2;
    logic                 cs_m3;
    logic                 cs_low;
    logic                 frame_rst_n;

    logic [CNT_W-1:0]     rx_cnt;
    logic [IN_W-1:0]      in_word;
    logic [CNT_W-1:0]     tx_idx;
    logic                 frame_done;
    logic                 done_tgl;
    logic [3:0]           cfg_addr;
    logic                 cfg_pol;
    logic                 cfg_order;

    logic                 dn_m1;
    logic                 dn_m2;
    logic                 dn_m3;
    ahp_cv_e              cv_state;
    logic [7:0]           cv_cnt;
    logic                 cur_pol;
    logic                 cur_order;
    logic [RES_W-1:0]     result;
    logic                 res_pol;
    logic                 res_order;

    wire                  cs_steady;
    wire  [CNT_W-1:0]     word_len;
    wire                  rx_full;
    wire                  at_last;
    wire                  conv_start;
    wire                  conv_end;
    wire                  sdo_bit;

    ////////////////////////////////////////////////////////////////////////
    // output bit select for position idx of the current word

    function automatic logic pick_bit(
        input logic [RES_W-1:0] res,
        input logic             msb_first,
        input logic             unipolar,
        input logic [CNT_W-1:0] idx
    );
        logic b;
        b = 1'b0;
        if (idx < CNT_W'(RES_W)) begin
            if (msb_first)
                b = res[4'(RES_W - 1) - idx[3:0]];
            else
                b = res[idx[3:0]];
        end else if (!msb_first && !unipolar) begin
            b = res[RES_W-1];
        end
        return b;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // chip select deglitch on falling conversion clock edges

    always_ff @(negedge conv_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_m1 <= 1'b1;
            cs_m2 <= 1'b1;
            cs_m3 <= 1'b1;
        end else begin
            cs_m1 <= link.cs_n;
            cs_m2 <= cs_m1;
            cs_m3 <= cs_m2;
        end
    end

    // change taken only once it held across two sampled edges
    assign cs_steady = (cs_m2 == cs_m3);

    always_ff @(negedge conv_clk or negedge rst_n) begin
        if (!rst_n)
            cs_low <= 1'b0;
        else if (cs_steady)
            cs_low <= ~cs_m3;
    end

    assign cs_seen     = cs_low;
    // shifter is held cleared outside a recognised frame
    assign frame_rst_n = rst_n & cs_low;

    ////////////////////////////////////////////////////////////////////////
    // shift clock domain

    assign word_len = wl_bits(in_word[POS_WL_HI:POS_WL_LO]);
    assign rx_full  = (rx_cnt >= CNT_W'(IN_W));
    assign at_last  = rx_full && !frame_done && (tx_idx == word_len - 5'h01);

    // input word on rising edges, later bits ignored
    always_ff @(posedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            rx_cnt  <= '0;
            in_word <= '0;
        end else if (!rx_full) begin
            rx_cnt  <= rx_cnt + 5'h01;
            in_word <= {in_word[IN_W-2:0], link.sdi};
        end
    end

    // output position advances on falling edges
    always_ff @(negedge link.sclk or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_idx     <= '0;
            frame_done <= 1'b0;
        end else if (!frame_done) begin
            tx_idx     <= tx_idx + 5'h01;
            frame_done <= at_last;
        end
    end

    // last falling edge hands the request to the conversion side
    always_ff @(negedge link.sclk or negedge rst_n) begin
        if (!rst_n) begin
            done_tgl  <= 1'b0;
            cfg_addr  <= '0;
            cfg_pol   <= POLARITY_RST;
            cfg_order <= ORDER_RST;
        end else if (at_last) begin
            done_tgl  <= ~done_tgl;
            cfg_addr  <= in_word[POS_ADDR_HI:POS_ADDR_LO];
            cfg_pol   <= in_word[POS_POLARITY];
            cfg_order <= in_word[POS_ORDER];
        end
    end

    // first bit stands from frame start, before the first rise
    assign sdo_bit     = pick_bit(result, res_order, res_pol, tx_idx);
    assign link.sdo    = sdo_bit & cs_low;
    assign link.sdo_oe = cs_low;

    ////////////////////////////////////////////////////////////////////////
    // conversion sequencing on the conversion clock

    always_ff @(negedge conv_clk or negedge rst_n) begin
        if (!rst_n) begin
            dn_m1 <= 1'b0;
            dn_m2 <= 1'b0;
            dn_m3 <= 1'b0;
        end else begin
            dn_m1 <= done_tgl;
            dn_m2 <= dn_m1;
            dn_m3 <= dn_m2;
        end
    end

    assign conv_start = (dn_m2 ^ dn_m3) && (cv_state == AHP_CV_IDLE);
    assign conv_end   = (cv_state == AHP_CV_RUN) && (cv_cnt == 8'(CONV_CYC - 1));

    always_ff @(negedge conv_clk or negedge rst_n) begin
        if (!rst_n) begin
            cv_state <= AHP_CV_IDLE;
            cv_cnt   <= '0;
        end else begin
            unique case (cv_state)
                AHP_CV_IDLE: begin
                    cv_cnt <= '0;
                    if (conv_start)
                        cv_state <= AHP_CV_RUN;
                end
                AHP_CV_RUN: begin
                    cv_cnt <= cv_cnt + 8'h01;
                    if (conv_end)
                        cv_state <= AHP_CV_IDLE;
                end
            endcase
        end
    end

    // request settings latched at start, result with its format at end
    always_ff @(negedge conv_clk or negedge rst_n) begin
        if (!rst_n) begin
            mux_address <= '0;
            cur_pol     <= POLARITY_RST;
            cur_order   <= ORDER_RST;
            conv_busy   <= 1'b0;
        end else if (conv_start) begin
            mux_address <= cfg_addr;
            cur_pol     <= cfg_pol;
            cur_order   <= cfg_order;
            conv_busy   <= 1'b1;
        end else if (conv_end) begin
            conv_busy   <= 1'b0;
        end
    end

    always_ff @(negedge conv_clk or negedge rst_n) begin
        if (!rst_n) begin
            result    <= '0;
            res_pol   <= POLARITY_RST;
            res_order <= ORDER_RST;
        end else if (conv_end) begin
            result    <= sample_value;
            res_pol   <= cur_pol;
            res_order <= cur_order;
        end
    end

endmodule // ahp_device

//--- ahp_host.sv
// host end of the adc serial host port: bit-banged select, shift clock
// and serial input from the core clock, serial output read back.
// assumes one converter per select line and the bench resolving sdo.
`timescale 1ns/100ps
module ahp_host
    import ahp_pkg::*;
#(
    parameter logic [15:0] SCLK_HALF = 16'(ahp_pkg::SCLK_HALF_CYC),
    parameter logic [15:0] SETUP_CYC = 16'(ahp_pkg::SETUP_CYC),
    parameter logic [15:0] CONV_WAIT = 16'(ahp_pkg::CONV_WAIT_CYC)
) (
    ahp_link_if.host         link,
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        start,
    input  wire logic [7:0]  cmd_word,
    output logic             busy,
    output logic [15:0]      rx_word,
    output logic             rx_valid
);

    ////////////////////////////////////////////////////////////////////////
    // declarations

    typedef enum logic [1:0] {
        AHP_HS_IDLE,
        AHP_HS_SETUP,
        AHP_HS_SHIFT,
        AHP_HS_CONV
    } ahp_hs_e;

    ahp_hs_e                 state;
    logic                    sclk;
    logic                    cs_n;
    logic                    sdi;
    logic [7:0]              tx_sr;
    logic [15:0]             rx_sr;
    logic [CNT_W-1:0]        nbits;
    logic [CNT_W-1:0]        bit_cnt;
    logic [15:0]             wait_cnt;
    logic                    sdo_m1;
    logic                    sdo_m2;

    wire                     wait_done;
    wire                     last_fall;

    assign link.sclk = sclk;
    assign link.cs_n = cs_n;
    assign link.sdi  = sdi;

    assign wait_done = (wait_cnt == 16'h0000);
    assign last_fall = sclk && (bit_cnt == nbits);

    ////////////////////////////////////////////////////////////////////////
    // serial output pin synchroniser

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sdo_m1 <= 1'b0;
            sdo_m2 <= 1'b0;
        end else begin
            sdo_m1 <= link.sdo;
            sdo_m2 <= sdo_m1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transfer sequencer

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state    <= AHP_HS_IDLE;
            sclk     <= 1'b0;
            cs_n     <= 1'b1;
            sdi      <= 1'b0;
            tx_sr    <= '0;
            rx_sr    <= '0;
            nbits    <= '0;
            bit_cnt  <= '0;
            wait_cnt <= '0;
            busy     <= 1'b0;
            rx_word  <= '0;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            unique case (state)
                AHP_HS_IDLE: begin
                    sclk <= 1'b0;
                    if (start) begin
                        cs_n     <= 1'b0;
                        sdi      <= cmd_word[7];
                        tx_sr    <= {cmd_word[6:0], 1'b0};
                        nbits    <= wl_bits(cmd_word[1:0]);
                        bit_cnt  <= '0;
                        rx_sr    <= '0;
                        wait_cnt <= SETUP_CYC - 16'h0001;
                        busy     <= 1'b1;
                        state    <= AHP_HS_SETUP;
                    end
                end
                AHP_HS_SETUP: begin
                    if (wait_done) begin
                        wait_cnt <= SCLK_HALF - 16'h0001;
                        state    <= AHP_HS_SHIFT;
                    end else begin
                        wait_cnt <= wait_cnt - 16'h0001;
                    end
                end
                AHP_HS_SHIFT: begin
                    if (!wait_done) begin
                        wait_cnt <= wait_cnt - 16'h0001;
                    end else if (!sclk) begin
                        wait_cnt <= SCLK_HALF - 16'h0001;
                        sclk     <= 1'b1;
                        rx_sr    <= {rx_sr[14:0], sdo_m2};
                        bit_cnt  <= bit_cnt + 5'h01;
                    end else begin
                        wait_cnt <= SCLK_HALF - 16'h0001;
                        sclk     <= 1'b0;
                        sdi      <= tx_sr[7];
                        tx_sr    <= {tx_sr[6:0], 1'b0};
                        if (last_fall) begin
                            cs_n     <= 1'b1;
                            rx_word  <= rx_sr;
                            rx_valid <= 1'b1;
                            wait_cnt <= CONV_WAIT - 16'h0001;
                            state    <= AHP_HS_CONV;
                        end
                    end
                end
                AHP_HS_CONV: begin
                    if (wait_done) begin
                        busy  <= 1'b0;
                        state <= AHP_HS_IDLE;
                    end else begin
                        wait_cnt <= wait_cnt - 16'h0001;
                    end
                end
            endcase
        end
    end

endmodule // ahp_host

//--- ahp_link_asserts.sv
// checker of the four wire link between the host end and the converter end.
// takes the link signals plus the host clock and reset as plain inputs.
`timescale 1ns/100ps
module ahp_link_asserts (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic sdo,
    input wire logic sdo_oe
);
    logic       sclk_q;
    logic [4:0] n_rise;
    logic [4:0] next_n_rise;
    wire        sclk_rise = sclk && !sclk_q;

    ////////////////////////////////////////////////////////////////////////////
    // rising shift clocks counted per frame
    assign next_n_rise = cs_n ? 5'h00 : (sclk_rise ? n_rise + 5'h01 : n_rise);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 1'b0;
            n_rise <= 5'h00;
        end else begin
            sclk_q <= sclk;
            n_rise <= next_n_rise;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_oe_after_select: assert property ($fell(cs_n) |-> ##[1:40] sdo_oe)
        else $error("data out not enabled after select");
    a_oe_after_release: assert property ($rose(cs_n) |-> ##[1:40] !sdo_oe)
        else $error("data out still enabled after release");
    a_sdo_idle_zero: assert property (!sdo_oe |-> !sdo)
        else $error("data out active while not driven");
    a_sclk_idle_low: assert property (cs_n |-> !sclk)
        else $error("shift clock high while deselected");
    a_select_gap_low: assert property ($fell(cs_n) |-> !sclk [*8])
        else $error("shift clock moved while select settles");
    a_sdo_steady_high: assert property (
        sclk && $past(sclk) && sdo_oe && $past(sdo_oe) |-> $stable(sdo))
        else $error("data out changed while shift clock high");
    a_sdi_steady_high: assert property (sclk && $past(sclk) |-> $stable(sdi))
        else $error("data in changed while shift clock high");
    a_frame_clock_count: assert property (
        $rose(cs_n) |-> n_rise inside {5'h08, 5'h0a, 5'h0c, 5'h10})
        else $error("frame clock count not a word length");
    a_release_hold: assert property ($rose(cs_n) |-> cs_n [*8])
        else $error("select lowered too soon after frame");

    cover property ($rose(cs_n) && n_rise == 5'h08);
    cover property ($rose(cs_n) && n_rise == 5'h10);
    cover property ($fell(sdo_oe));
endmodule // ahp_link_asserts

//--- adc_serial_host_port_tb.sv
// testbench: host and converter ends face each other on one link; a second
// converter on its own link is driven by the bench with select glitches.
`timescale 1ns/100ps
module adc_serial_host_port_tb;
    import ahp_pkg::*;
    logic             core_clk;
    logic             conv_clk;
    logic             rst_n;
    logic             start;
    logic [7:0]       cmd_word;
    logic [RES_W-1:0] sample_value;
    logic             busy;
    logic             rx_valid;
    logic [15:0]      rx_word;
    logic [3:0]       mux_address;
    logic [3:0]       mux_address_b;
    logic             conv_busy;
    logic             conv_busy_b;
    logic             cs_seen;
    logic             cs_seen_b;
    logic [RES_W-1:0] prev_res;
    logic             prev_msb;
    logic             prev_uni;
    int               n_mismatch;
    int               cmp_count;
    int               n_cyc;

    ahp_link_if link();
    ahp_link_if link_b();

    ahp_host #(.SETUP_CYC(16'h0028), .CONV_WAIT(16'h0190)) i_ahp_host (
        .link(link.host), .core_clk(core_clk), .rst_n(rst_n), .start(start),
        .cmd_word(cmd_word), .busy(busy), .rx_word(rx_word), .rx_valid(rx_valid));
    ahp_device i_ahp_device (
        .link(link.dev), .conv_clk(conv_clk), .rst_n(rst_n), .sample_value(sample_value),
        .mux_address(mux_address), .conv_busy(conv_busy), .cs_seen(cs_seen));
    ahp_device i_ahp_device_b (
        .link(link_b.dev), .conv_clk(conv_clk), .rst_n(rst_n), .sample_value(10'h000),
        .mux_address(mux_address_b), .conv_busy(conv_busy_b), .cs_seen(cs_seen_b));
    ahp_link_asserts i_ahp_link_asserts (
        .core_clk(core_clk), .rst_n(rst_n), .sclk(link.sclk), .cs_n(link.cs_n),
        .sdi(link.sdi), .sdo(link.sdo), .sdo_oe(link.sdo_oe));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        conv_clk = 1'b0;
        #13;
        forever #32 conv_clk = ~conv_clk;
    end

    always @(posedge core_clk) begin
        n_cyc <= n_cyc + 1;
        if (n_cyc == 30000) begin
            n_mismatch = n_mismatch + 1;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial stream of one word, first bit ends highest, right aligned
    function automatic logic [15:0] exp_word(input logic [9:0] r, input logic m, u,
                                             input logic [1:0] wl);
        logic [15:0] s;
        int          n;
        n = (wl == WL_8) ? 8 : (wl == WL_10) ? 10 : (wl == WL_12) ? 12 : 16;
        for (int i = 0; i < 16; i++) begin
            s[15-i] = m ? (i < 10 ? r[9-i] : 1'b0) : (i < 10 ? r[i] : (u ? 1'b0 : r[9]));
        end
        return s >> (16 - n);
    endfunction

    task chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task frame(input logic [7:0] c, input logic [9:0] s);
        int k;
        @(posedge core_clk);
        start <= 1'b1;
        cmd_word <= c;
        sample_value <= s;
        @(posedge core_clk);
        start <= 1'b0;
        @(posedge core_clk);
        start <= 1'b1;
        cmd_word <= ~c;
        @(posedge core_clk);
        start <= 1'b0;
        chk("busy set", 16'(busy), 16'h0001);
        for (k = 0; k < 2000 && rx_valid !== 1'b1; k++) begin
            @(posedge core_clk);
            #1;
        end
        chk("rx_valid", 16'(rx_valid), 16'h0001);
        chk("cs_seen held", 16'(cs_seen), 16'h0001);
        chk("rx_word", rx_word, exp_word(prev_res, prev_msb, prev_uni, c[1:0]));
        for (k = 0; k < 2000 && busy !== 1'b0; k++) begin
            @(posedge core_clk);
            #1;
        end
        chk("busy clear", 16'(busy), 16'h0000);
        chk("cs_seen idle", 16'(cs_seen), 16'h0000);
        chk("mux_address", 16'(mux_address), 16'(c[7:4]));
        chk("conv_busy", 16'(conv_busy), 16'h0000);
        prev_res = s;
        prev_msb = c[POS_ORDER];
        prev_uni = c[POS_POLARITY];
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        start = 1'b0;
        cmd_word = 8'h00;
        sample_value = 10'h000;
        link_b.cs_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.sdi = 1'b0;
        prev_res = 10'h000;
        prev_msb = ORDER_RST;
        prev_uni = POLARITY_RST;
        void'($urandom(23));
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        #1;
        chk("idle cs_n", 16'(link.cs_n), 16'h0001);
        chk("idle sclk", 16'(link.sclk), 16'h0000);
        $display("test reset done");
        // all order, polarity and length codes first, then random words
        for (int i = 0; i < 24; i++) begin
            frame(i < 16 ? {4'($urandom), 4'(i)} : 8'($urandom),
                  i == 1 ? 10'h200 : (i == 2 ? 10'h3ff : 10'($urandom)));
        end
        $display("test frames done");
        @(posedge core_clk);
        link_b.cs_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        link_b.cs_n <= 1'b1;
        repeat (60) @(posedge core_clk);
        chk("glitch seen", 16'(cs_seen_b), 16'h0000);
        chk("glitch oe", 16'(link_b.sdo_oe), 16'h0000);
        link_b.cs_n <= 1'b0;
        repeat (60) @(posedge core_clk);
        chk("select oe", 16'(link_b.sdo_oe), 16'h0001);
        chk("select seen", 16'(cs_seen_b), 16'h0001);
        chk("first bit", 16'(link_b.sdo), 16'h0000);
        link_b.cs_n <= 1'b1;
        repeat (60) @(posedge core_clk);
        chk("release oe", 16'(link_b.sdo_oe), 16'h0000);
        chk("release seen", 16'(cs_seen_b), 16'h0000);
        chk("idle conv_busy_b", 16'(conv_busy_b), 16'h0000);
        chk("idle mux_address_b", 16'(mux_address_b), 16'h0000);
        $display("test glitch done");
        tally_and_finish();
    end
endmodule // adc_serial_host_port_tb
